// ===== gpc_top.sv
// Setup, drive, pull, debounce and edge interrupt logic of general purpose pins 3 and 4.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpc_top #(
  parameter int CNT_W = `GPC_CNT_W,
  parameter int DBNC_8_CYC = `GPC_DBNC_8_MS * `GPC_US_PER_MS * `GPC_CLK_MHZ,
  parameter int DBNC_16_CYC = `GPC_DBNC_16_MS * `GPC_US_PER_MS * `GPC_CLK_MHZ,
  parameter int DBNC_32_CYC = `GPC_DBNC_32_MS * `GPC_US_PER_MS * `GPC_CLK_MHZ
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire gpc_pkg::gpc_addr_t i_addr,
  input wire gpc_pkg::gpc_byte_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output gpc_pkg::gpc_byte_t o_rdata,
  input wire logic [`GPC_NPIN-1:0] i_pin_in,
  output logic [`GPC_NPIN-1:0] o_pin_out,
  output logic [`GPC_NPIN-1:0] o_pin_oe,
  output logic [`GPC_NPIN-1:0] o_pullup_enable,
  output logic [`GPC_NPIN-1:0] o_pulldown_enable,
  input wire logic [`GPC_NPIN-1:0] i_alt_out,
  output logic [`GPC_NPIN-1:0] o_alt_in_active,
  output logic o_irq
);
  import gpc_pkg::*;

  // Tells whether an address selects the setup register of a pin.
  function automatic logic pin_hit(input gpc_addr_t addr, input int idx);
    pin_hit = (idx == 0) ? (addr == `GPC_PIN3_SETUP_ADDR) : (addr == `GPC_PIN4_SETUP_ADDR);
  endfunction : pin_hit

  // Builds the read value of a setup register, with the live level in input mode.
  function automatic gpc_byte_t read_setup(input gpc_byte_t cfg, input logic lvl, input logic in_mode);
    gpc_byte_t val;
    val = cfg;
    if (in_mode) begin
      val[`GPC_IN_LEVEL_BIT] = lvl;
    end
    read_setup = val;
  endfunction : read_setup

  // Applies the polarity that the direction bit gives to an alternate input.
  function automatic logic alt_active(input logic lvl, input logic dir);
    alt_active = dir ? lvl : !lvl;
  endfunction : alt_active

  gpc_byte_t setup [`GPC_NPIN];
  gpc_byte_t next_setup [`GPC_NPIN];
  logic [`GPC_NPIN-1:0] alt_en, next_alt_en;
  logic [`GPC_NPIN-1:0] status, next_status;
  logic [`GPC_NPIN-1:0] mask, next_mask;
  gpc_byte_t rdata, next_rdata;
  logic irq, next_irq;
  logic [`GPC_NPIN-1:0] pin_out, next_pin_out;
  logic [`GPC_NPIN-1:0] pin_oe, next_pin_oe;
  logic [`GPC_NPIN-1:0] pull_up, next_pull_up;
  logic [`GPC_NPIN-1:0] pull_down, next_pull_down;
  logic [`GPC_NPIN-1:0] alt_act, next_alt_act;
  logic [`GPC_NPIN-1:0] drive_hi;
  logic [`GPC_NPIN-1:0] in_mode;
  logic [`GPC_NPIN-1:0] lvl;
  logic [`GPC_NPIN-1:0] rise;
  logic [`GPC_NPIN-1:0] fall;
  logic [`GPC_NPIN-1:0] evt;

  // One debounce filter per pin, plus the edge event and mode decode of that pin.
  for (genvar g = 0; g < `GPC_NPIN; g++) begin : g_pin
    gpc_filt_if u_if ();

    // Input mode needs the alternate function off and direction 1.
    assign in_mode[g] = !alt_en[g] && setup[g][`GPC_DIRECTION_BIT];
    assign u_if.raw = i_pin_in[g];
    assign u_if.en = in_mode[g];
    assign u_if.sel = setup[g][`GPC_DBNC_MSB:`GPC_DBNC_LSB];
    assign lvl[g] = u_if.level;
    assign rise[g] = u_if.rise;
    assign fall[g] = u_if.fall;

    // Edge events count only in input mode and only for the selected edges.
    assign evt[g] = in_mode[g] && (
      (rise[g] && setup[g][`GPC_EDGE_RISE_BIT]) || (fall[g] && setup[g][`GPC_EDGE_FALL_BIT]));

    gpc_pin_filter #(
      .CNT_W(CNT_W),
      .LIM_8(DBNC_8_CYC),
      .LIM_16(DBNC_16_CYC),
      .LIM_32(DBNC_32_CYC)
    ) u_filt (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .filt(u_if.filt)
    );
  end

  // Register writes, sticky interrupt status and the one-cycle read answer.
  always_comb begin
    next_alt_en = alt_en;
    next_mask = mask;
    next_status = status | evt; // Hardware set wins over a clear in the same cycle.
    for (int k = 0; k < `GPC_NPIN; k++) begin
      next_setup[k] = setup[k];
      if (i_wr && pin_hit(i_addr, k)) begin
        next_setup[k] = i_wdata;
        if (in_mode[k]) begin
          next_setup[k][`GPC_IN_LEVEL_BIT] = setup[k][`GPC_IN_LEVEL_BIT];
        end
      end
    end
    if (i_wr) begin
      case (i_addr)
        `GPC_IRQ_STATUS_ADDR: next_status = (status & ~i_wdata[`GPC_NPIN-1:0]) | evt;
        `GPC_IRQ_MASK_ADDR: next_mask = i_wdata[`GPC_NPIN-1:0];
        `GPC_ALT_ENABLE_ADDR: next_alt_en = i_wdata[`GPC_NPIN-1:0];
        default: ;
      endcase
    end
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        `GPC_PIN3_SETUP_ADDR: next_rdata = read_setup(setup[0], lvl[0], in_mode[0]);
        `GPC_PIN4_SETUP_ADDR: next_rdata = read_setup(setup[1], lvl[1], in_mode[1]);
        `GPC_IRQ_STATUS_ADDR: next_rdata = gpc_byte_t'(status);
        `GPC_IRQ_MASK_ADDR: next_rdata = gpc_byte_t'(mask);
        `GPC_ALT_ENABLE_ADDR: next_rdata = gpc_byte_t'(alt_en);
        default: next_rdata = '0;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  // Registers the software visible state.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int k = 0; k < `GPC_NPIN; k++) begin
        setup[k] <= `GPC_SETUP_RESET;
      end
      alt_en <= '0;
      status <= '0;
      mask <= '0;
      rdata <= '0;
      irq <= 1'b0;
    end else begin
      for (int k = 0; k < `GPC_NPIN; k++) begin
        setup[k] <= next_setup[k];
      end
      alt_en <= next_alt_en;
      status <= next_status;
      mask <= next_mask;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // Pin drive, pull selection and alternate input decode for every pin.
  always_comb begin
    for (int k = 0; k < `GPC_NPIN; k++) begin
      // The alternate output is taken as active high; the drive does not depend on direction while alt_en is set.
      drive_hi[k] = alt_en[k] ? i_alt_out[k] : setup[k][`GPC_OUT_LEVEL_BIT];
      next_pin_out[k] = 1'b0;
      next_pin_oe[k] = 1'b0;
      next_pull_up[k] = 1'b0;
      next_pull_down[k] = 1'b0;
      if (!in_mode[k]) begin
        // Low is always driven; high is driven by push-pull and released by open-drain.
        next_pin_out[k] = drive_hi[k];
        next_pin_oe[k] = !drive_hi[k] || setup[k][`GPC_DRIVE_TYPE_BIT];
      end else begin
        // The stored input level bit never reaches the pin in either mode.
        next_pull_up[k] = !setup[k][`GPC_OUT_LEVEL_BIT];
        next_pull_down[k] = setup[k][`GPC_OUT_LEVEL_BIT];
      end
      next_alt_act[k] = alt_en[k] && alt_active(lvl[k], setup[k][`GPC_DIRECTION_BIT]);
    end
  end

  // Registers the pin side outputs; the input level bit is not used here.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_out <= '0;
      pin_oe <= '0;
      pull_up <= '0;
      pull_down <= '0;
      alt_act <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pull_up <= next_pull_up;
      pull_down <= next_pull_down;
      alt_act <= next_alt_act;
    end
  end

  // Drives the top level outputs from their registers.
  assign o_rdata = rdata;
  assign o_irq = irq;
  assign o_pin_out = pin_out;
  assign o_pin_oe = pin_oe;
  assign o_pullup_enable = pull_up;
  assign o_pulldown_enable = pull_down;
  assign o_alt_in_active = alt_act;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // Checks for pin 3, which shares every path with pin 4, plus the active-low alternate input check of pin 4 and the interrupt output and idle read data checks.
  sequence s_in_write;
    i_wr && pin_hit(i_addr, 0) && in_mode[0];
  endsequence

  sequence s_out_high;
    !in_mode[0] && !alt_en[0] && setup[0][`GPC_OUT_LEVEL_BIT];
  endsequence

  a_in_level_kept: assert property (
    s_in_write |=> (setup[0][`GPC_IN_LEVEL_BIT] == $past(setup[0][`GPC_IN_LEVEL_BIT])))
    else $error("Input level bit took a write in input mode.");

  a_input_no_drive: assert property (
    (!alt_en[0] && setup[0][`GPC_DIRECTION_BIT]) |=> !o_pin_oe[0])
    else $error("Pin driven while set as input.");

  a_output_low_drive: assert property (
    (!alt_en[0] && !setup[0][`GPC_DIRECTION_BIT] && !setup[0][`GPC_OUT_LEVEL_BIT]) |=> (o_pin_oe[0] && !o_pin_out[0]))
    else $error("Output level 0 did not drive the pin low.");

  a_open_drain_release: assert property (
    (s_out_high and (!setup[0][`GPC_DRIVE_TYPE_BIT])) |=> !o_pin_oe[0])
    else $error("Open-drain high was driven instead of released.");

  a_push_pull_high: assert property (
    (s_out_high and setup[0][`GPC_DRIVE_TYPE_BIT]) |=> (o_pin_oe[0] && o_pin_out[0]))
    else $error("Push-pull high was not driven.");

  a_pull_select: assert property (
    in_mode[0] |=> (o_pullup_enable[0] == !$past(setup[0][`GPC_OUT_LEVEL_BIT])
      && o_pulldown_enable[0] == $past(setup[0][`GPC_OUT_LEVEL_BIT])))
    else $error("Wrong pull selected in input mode.");

  a_in_level_read: assert property (
    (i_rd && pin_hit(i_addr, 0) && in_mode[0]) |=> (o_rdata[`GPC_IN_LEVEL_BIT] == $past(lvl[0])))
    else $error("Input level bit did not show the sensed level.");

  a_edge_irq_gate: assert property (
    (!in_mode[0] && !status[0]) |=> !status[0])
    else $error("Edge status set while pin is an output.");

  a_rise_sets_status: assert property (
    (in_mode[0] && rise[0] && setup[0][`GPC_EDGE_RISE_BIT]) |=> status[0])
    else $error("Selected rising edge did not set the status bit.");

  a_fall_only_mode: assert property (
    (in_mode[0] && rise[0] && !fall[0] && !setup[0][`GPC_EDGE_RISE_BIT] && !status[0]) |=> !status[0])
    else $error("Unselected rising edge set the status bit.");

  a_alt_polarity: assert property (
    (alt_en[1] && !setup[1][`GPC_DIRECTION_BIT]) |=> (o_alt_in_active[1] == !$past(lvl[1])))
    else $error("Active-low alternate input decoded wrongly.");

  a_irq_follows: assert property (
    o_irq == |(status & mask))
    else $error("Interrupt output does not match the unmasked status bits.");

  a_fall_sets_status: assert property (
    (in_mode[0] && fall[0] && setup[0][`GPC_EDGE_FALL_BIT]) |=> status[0])
    else $error("Selected falling edge did not set the status bit.");

  a_out_read_stored: assert property (
    (i_rd && pin_hit(i_addr, 0) && !in_mode[0]) |=> (o_rdata == $past(setup[0])))
    else $error("Output mode read did not return the stored setup.");

  a_setup_write_lands: assert property (
    (i_wr && pin_hit(i_addr, 0) && !in_mode[0]) |=> (setup[0] == $past(i_wdata)))
    else $error("Setup write in output mode was not stored.");

  a_rdata_idle: assert property (
    !i_rd |=> (o_rdata == '0))
    else $error("Read data not zero outside a read answer.");

  // The pin 3 checks for pin 4 except the edge set, output-mode readback and output-mode write checks, plus the alternate function paths that only pin 4 exercises.
  sequence s_pin4_in_write;
    i_wr && pin_hit(i_addr, 1) && in_mode[1];
  endsequence

  sequence s_pin4_out_high;
    !in_mode[1] && !alt_en[1] && setup[1][`GPC_OUT_LEVEL_BIT];
  endsequence

  a_pin4_level_kept: assert property (
    s_pin4_in_write |=> (setup[1][`GPC_IN_LEVEL_BIT] == $past(setup[1][`GPC_IN_LEVEL_BIT])))
    else $error("Pin 4 input level bit took a write in input mode.");

  a_pin4_no_drive: assert property (
    (!alt_en[1] && setup[1][`GPC_DIRECTION_BIT]) |=> !o_pin_oe[1])
    else $error("Pin 4 driven while set as input.");

  a_pin4_low_drive: assert property (
    (!alt_en[1] && !setup[1][`GPC_DIRECTION_BIT] && !setup[1][`GPC_OUT_LEVEL_BIT]) |=> (o_pin_oe[1] && !o_pin_out[1]))
    else $error("Pin 4 output level 0 did not drive low.");

  a_pin4_od_release: assert property (
    (s_pin4_out_high and (!setup[1][`GPC_DRIVE_TYPE_BIT])) |=> !o_pin_oe[1])
    else $error("Pin 4 open-drain high was driven instead of released.");

  a_pin4_pp_high: assert property (
    (s_pin4_out_high and setup[1][`GPC_DRIVE_TYPE_BIT]) |=> (o_pin_oe[1] && o_pin_out[1]))
    else $error("Pin 4 push-pull high was not driven.");

  a_pin4_pull_select: assert property (
    in_mode[1] |=> (o_pullup_enable[1] == !$past(setup[1][`GPC_OUT_LEVEL_BIT])
      && o_pulldown_enable[1] == $past(setup[1][`GPC_OUT_LEVEL_BIT])))
    else $error("Pin 4 wrong pull selected in input mode.");

  a_pin4_level_read: assert property (
    (i_rd && pin_hit(i_addr, 1) && in_mode[1]) |=> (o_rdata[`GPC_IN_LEVEL_BIT] == $past(lvl[1])))
    else $error("Pin 4 input level bit did not show the sensed level.");

  a_pin4_edge_gate: assert property (
    (!in_mode[1] && !status[1]) |=> !status[1])
    else $error("Pin 4 edge status set while pin is an output.");

  a_alt_active_high: assert property (
    (alt_en[1] && setup[1][`GPC_DIRECTION_BIT]) |=> (o_alt_in_active[1] == $past(lvl[1])))
    else $error("Active-high alternate input decoded wrongly.");

  a_alt_out_drive: assert property (
    (alt_en[1] && setup[1][`GPC_DRIVE_TYPE_BIT]) |=> (o_pin_oe[1] && o_pin_out[1] == $past(i_alt_out[1])))
    else $error("Alternate output not driven active high.");

  a_alt_no_pull: assert property (
    alt_en[1] |=> (!o_pullup_enable[1] && !o_pulldown_enable[1]))
    else $error("Pull enabled while the alternate function owns the pin.");
endmodule : gpc_top

// ===== gpc_regs.svh
// Register map, field positions, encodings and timing constants of the pin setup block.
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_NPIN 2
`define GPC_PIN3_SETUP_ADDR 8'h73
`define GPC_PIN4_SETUP_ADDR 8'h74
`define GPC_IRQ_STATUS_ADDR 8'h80
`define GPC_IRQ_MASK_ADDR 8'h81
`define GPC_ALT_ENABLE_ADDR 8'h82

`define GPC_SETUP_RESET 8'h00
`define GPC_DRIVE_TYPE_BIT 0
`define GPC_DIRECTION_BIT 1
`define GPC_IN_LEVEL_BIT 2
`define GPC_OUT_LEVEL_BIT 3
`define GPC_EDGE_FALL_BIT 4
`define GPC_EDGE_RISE_BIT 5
`define GPC_DBNC_LSB 6
`define GPC_DBNC_MSB 7

`define GPC_DBNC_OFF 2'h0
`define GPC_DBNC_8MS 2'h1
`define GPC_DBNC_16MS 2'h2
`define GPC_DBNC_32MS 2'h3

`define GPC_DBNC_8_MS 8
`define GPC_DBNC_16_MS 16
`define GPC_DBNC_32_MS 32
`define GPC_US_PER_MS 1000
`define GPC_CLK_MHZ 25
`define GPC_CNT_W 20

`endif

// ===== gpc_pkg.sv
// Types shared by the pin setup block and its debounce filter.
package gpc_pkg;
  typedef logic [7:0] gpc_byte_t;
  typedef logic [7:0] gpc_addr_t;
  typedef logic [1:0] gpc_dbnc_t;
endpackage : gpc_pkg

// ===== gpc_filt_if.sv
// Signals between the pin setup block and one debounce filter.
`timescale 1ns/1ps
interface gpc_filt_if;
  import gpc_pkg::*;
  logic raw;
  logic en;
  gpc_dbnc_t sel;
  logic level;
  logic rise;
  logic fall;
  modport filt (input raw, input en, input sel, output level, output rise, output fall);
  modport user (output raw, output en, output sel, input level, input rise, input fall);
endinterface : gpc_filt_if

// ===== gpc_pin_filter.sv
// Debounce filter and edge detector for one general purpose pin.
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpc_pin_filter #(
  parameter int CNT_W = `GPC_CNT_W,
  parameter int LIM_8 = `GPC_DBNC_8_MS * `GPC_US_PER_MS * `GPC_CLK_MHZ,
  parameter int LIM_16 = `GPC_DBNC_16_MS * `GPC_US_PER_MS * `GPC_CLK_MHZ,
  parameter int LIM_32 = `GPC_DBNC_32_MS * `GPC_US_PER_MS * `GPC_CLK_MHZ
) (
  input wire logic i_clk,
  input wire logic i_reset,
  gpc_filt_if.filt filt
);
  import gpc_pkg::*;

  logic primed, next_primed;
  logic level, next_level;
  logic rise, next_rise;
  logic fall, next_fall;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] limit;

  // Picks the number of stable cycles that the selected debounce time needs.
  always_comb begin
    case (filt.sel)
      `GPC_DBNC_8MS: limit = CNT_W'(LIM_8);
      `GPC_DBNC_16MS: limit = CNT_W'(LIM_16);
      default: limit = CNT_W'(LIM_32);
    endcase
  end

  // Accepts a new level at once without debounce, else after it has held for the whole time.
  always_comb begin
    next_primed = 1'b1;
    next_cnt = '0;
    next_level = level;
    if (!primed) begin
      next_level = filt.raw; // First sample after reset loads without an edge.
    end else if (filt.raw != level) begin
      if (!filt.en || filt.sel == `GPC_DBNC_OFF) begin
        next_level = filt.raw;
      end else if (cnt >= limit - CNT_W'(1)) begin
        next_level = filt.raw;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
    next_rise = primed && next_level && !level;
    next_fall = primed && !next_level && level;
  end

  // Registers the filter state.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      primed <= 1'b0;
      cnt <= '0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      primed <= next_primed;
      cnt <= next_cnt;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  // Drives the filtered level and the one-cycle edge pulses.
  assign filt.level = level;
  assign filt.rise = rise;
  assign filt.fall = fall;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_debounce_hold: assert property (
    (primed && filt.en && filt.sel != `GPC_DBNC_OFF && cnt < limit - CNT_W'(1)) |=> $stable(level))
    else $error("Debounced level changed before the debounce time ran out.");

  a_no_debounce_follow: assert property (
    (primed && filt.en && filt.sel == `GPC_DBNC_OFF) |=> (level == $past(filt.raw)))
    else $error("Level did not follow the pin with debounce off.");
endmodule : gpc_pin_filter

// ===== gpc_pin_model.sv
// Pin-side model: external drivers, pull resistors and a floating node on each pin.
`timescale 1ns/1ps
module gpc_pin_model (
  input wire logic i_clk,
  input wire logic [1:0] i_pin_out,
  input wire logic [1:0] i_pin_oe,
  input wire logic [1:0] i_pullup_enable,
  input wire logic [1:0] i_pulldown_enable,
  input wire logic [1:0] i_ext_drive,
  input wire logic [1:0] i_ext_level,
  output logic [1:0] o_level
);
  logic [1:0] last = 2'h0; // Starts low so that a floating pin never reads as unknown.

  // Resolves each wire; an external driver is the stronger and wins a contention.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (i_ext_drive[p]) begin
        o_level[p] = i_ext_level[p];
      end else if (i_pin_oe[p]) begin
        o_level[p] = i_pin_out[p];
      end else if (i_pullup_enable[p]) begin
        o_level[p] = 1'b1;
      end else if (i_pulldown_enable[p]) begin
        o_level[p] = 1'b0;
      end else begin
        o_level[p] = ~last[p];
      end
    end
  end

  // Remembers the level so a floating pin never reads as a steady value.
  always_ff @(posedge i_clk) begin
    last <= o_level;
  end
endmodule : gpc_pin_model

// ===== gpc_top_tb.sv
// Self-checking testbench of the pin setup block with a pin-side model.
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpc_top_tb;
  import gpc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  gpc_addr_t i_addr = 8'h00;
  gpc_byte_t i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] alt_out = 2'h0;
  logic [1:0] ext_drive = 2'h0;
  logic [1:0] ext_level = 2'h0;
  gpc_byte_t o_rdata;
  logic [1:0] pin_level, pin_out, pin_oe, pu, pd, alt_act;
  logic irq;
  int miscompares = 0;
  int n_checks = 0;

  // Clock at 25 MHz.
  always #20 i_clk = ~i_clk;

  gpc_top #(.DBNC_8_CYC(8), .DBNC_16_CYC(16), .DBNC_32_CYC(32)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_level),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pullup_enable(pu), .o_pulldown_enable(pd),
    .i_alt_out(alt_out), .o_alt_in_active(alt_act), .o_irq(irq));

  gpc_pin_model model (.i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pullup_enable(pu),
    .i_pulldown_enable(pd), .i_ext_drive(ext_drive), .i_ext_level(ext_level), .o_level(pin_level));

  // Comparison, bus cycles and pin stimulus shared by all scenarios.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle
  task automatic wr(input gpc_addr_t a, input gpc_byte_t d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input string what, input gpc_addr_t a, input gpc_byte_t exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(what, exp, o_rdata);
  endtask : rdchk
  task automatic ext(input logic [1:0] d, input logic [1:0] l);
    @(posedge i_clk);
    ext_drive <= d;
    ext_level <= l;
  endtask : ext

  // Reset values, an unmapped address and the idle read bus.
  task automatic t_reset();
    wr(8'h90, 8'hFF);
    rdchk("unmapped", 8'h90, 8'h00);
    rdchk("pin3 setup", `GPC_PIN3_SETUP_ADDR, 8'h00);
    rdchk("pin4 setup", `GPC_PIN4_SETUP_ADDR, 8'h00);
    rdchk("status", `GPC_IRQ_STATUS_ADDR, 8'h00);
    rdchk("mask", `GPC_IRQ_MASK_ADDR, 8'h00);
    rdchk("alt", `GPC_ALT_ENABLE_ADDR, 8'h00);
    idle(1);
    chk("rdata idle", 8'h00, o_rdata);
  endtask : t_reset

  // Output mode on both pins: drive type and level give enable and value.
  task automatic t_drive();
    gpc_byte_t cfg [4] = '{8'h09, 8'h01, 8'h08, 8'h00};
    logic [1:0] ex [4] = '{2'h3, 2'h2, 2'h0, 2'h2};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        wr(gpc_addr_t'(8'h73 + p), cfg[i]);
        idle(3);
        chk("drive oe,out", {6'h00, ex[i]}, {6'h00, pin_oe[p], pin_out[p] & pin_oe[p]});
        chk("pulls off", 8'h00, {6'h00, pu[p], pd[p]});
      end
    end
  endtask : t_drive

  // Input mode with push-pull drive type: no drive, pull chosen by output level.
  task automatic t_pull();
    for (int p = 0; p < 2; p++) begin
      wr(gpc_addr_t'(8'h73 + p), 8'h03);
      idle(3);
      chk("pull up", 8'h02, {5'h00, pin_oe[p], pu[p], pd[p]});
      wr(gpc_addr_t'(8'h73 + p), 8'h0B);
      idle(3);
      chk("pull down", 8'h01, {5'h00, pin_oe[p], pu[p], pd[p]});
      rdchk("pull level", gpc_addr_t'(8'h73 + p), 8'h0B);
    end
  endtask : t_pull

  // Input level readback follows the pin and ignores writes.
  task automatic t_level();
    wr(`GPC_PIN3_SETUP_ADDR, 8'h02);
    ext(2'h1, 2'h1);
    idle(4);
    rdchk("level high", `GPC_PIN3_SETUP_ADDR, 8'h06);
    wr(`GPC_PIN3_SETUP_ADDR, 8'h02);
    rdchk("level kept", `GPC_PIN3_SETUP_ADDR, 8'h06);
    ext(2'h1, 2'h0);
    idle(4);
    wr(`GPC_PIN3_SETUP_ADDR, 8'h06);
    rdchk("level low", `GPC_PIN3_SETUP_ADDR, 8'h02);
    wr(`GPC_PIN3_SETUP_ADDR, 8'h04);
    rdchk("level bit ignored", `GPC_PIN3_SETUP_ADDR, 8'h00);
  endtask : t_level

  // Every edge selection, then masking and clearing of the interrupt.
  task automatic t_edge();
    logic [1:0] s;
    wr(`GPC_IRQ_MASK_ADDR, 8'h01);
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(`GPC_PIN3_SETUP_ADDR, {2'h0, s, 4'h2});
      wr(`GPC_IRQ_STATUS_ADDR, 8'h03);
      ext(2'h1, 2'h1);
      idle(6);
      rdchk("rise status", `GPC_IRQ_STATUS_ADDR, {7'h00, s[1]});
      chk("rise irq", {7'h00, s[1]}, {7'h00, irq});
      wr(`GPC_IRQ_STATUS_ADDR, 8'h01);
      ext(2'h1, 2'h0);
      idle(6);
      rdchk("fall status", `GPC_IRQ_STATUS_ADDR, {7'h00, s[0]});
    end
    wr(`GPC_IRQ_MASK_ADDR, 8'h00);
    idle(2);
    chk("masked irq", 8'h00, {7'h00, irq});
    wr(`GPC_IRQ_MASK_ADDR, 8'h01);
    idle(2);
    chk("unmasked irq", 8'h01, {7'h00, irq});
    wr(`GPC_IRQ_STATUS_ADDR, 8'h01);
    idle(2);
    chk("cleared irq", 8'h00, {7'h00, irq});
  endtask : t_edge

  // Released open-drain output toggled from outside raises no edge event.
  task automatic t_out_quiet();
    wr(`GPC_PIN3_SETUP_ADDR, 8'h38);
    wr(`GPC_IRQ_STATUS_ADDR, 8'h03);
    ext(2'h1, 2'h1);
    idle(6);
    ext(2'h1, 2'h0);
    idle(6);
    rdchk("output no edge", `GPC_IRQ_STATUS_ADDR, 8'h00);
  endtask : t_out_quiet

  // Each debounce time: a short glitch is dropped, a stable change is taken.
  task automatic t_dbnc();
    int n;
    gpc_byte_t c;
    for (int s = 1; s < 4; s++) begin
      n = 8 << (s - 1);
      c = gpc_byte_t'(8'h02 | (s << 6));
      wr(`GPC_PIN3_SETUP_ADDR, c);
      idle(n + 6);
      ext(2'h1, 2'h1);
      idle(n - 4);
      ext(2'h1, 2'h0);
      idle(n + 4);
      rdchk("glitch dropped", `GPC_PIN3_SETUP_ADDR, c);
      ext(2'h1, 2'h1);
      idle(n - 4);
      rdchk("not yet stable", `GPC_PIN3_SETUP_ADDR, c);
      idle(6);
      rdchk("stable taken", `GPC_PIN3_SETUP_ADDR, c | 8'h04);
      ext(2'h1, 2'h0);
      idle(n + 6);
    end
  endtask : t_dbnc

  // Alternate function: active-high output and input polarity from direction.
  task automatic t_alt();
    wr(`GPC_PIN4_SETUP_ADDR, 8'h01);
    wr(`GPC_ALT_ENABLE_ADDR, 8'h02);
    @(posedge i_clk);
    alt_out <= 2'h2;
    idle(3);
    chk("alt out high", 8'h03, {6'h00, pin_oe[1], pin_out[1]});
    alt_out <= 2'h0;
    idle(3);
    chk("alt out low", 8'h02, {6'h00, pin_oe[1], pin_out[1]});
    wr(`GPC_PIN4_SETUP_ADDR, 8'h02);
    alt_out <= 2'h2;
    ext(2'h2, 2'h2);
    idle(6);
    chk("alt in high", 8'h02, {6'h00, alt_act});
    wr(`GPC_PIN4_SETUP_ADDR, 8'h00);
    idle(3);
    chk("alt in inverted", 8'h00, {6'h00, alt_act});
    ext(2'h2, 2'h0);
    idle(6);
    chk("alt in low", 8'h02, {6'h00, alt_act});
  endtask : t_alt

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Main sequence after a two-cycle reset.
  initial begin
    idle(2);
    i_reset <= 1'b0;
    t_reset();
    t_drive();
    t_pull();
    t_level();
    t_edge();
    t_out_quiet();
    t_dbnc();
    t_alt();
    stop_test();
  end

  // Watchdog well beyond the expected run of about six hundred cycles.
  initial begin
    #200us;
    miscompares++;
    stop_test();
  end
endmodule : gpc_top_tb
